// file: rsc_consts.vh
// Purpose: Constants for the reset source controller.
// Assumes: 25 MHz system clock, APB slave with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
//
// Functional notes
// RULE_01: Reset on power-on, pin, supply dip, watchdog in run or halt.
// RULE_02: Power-on starts at address zero; port data and direction all ones.
// RULE_03: After power-on, pin or dip reset, hold internal reset 100 ms.
// RULE_04: Pin pulled low while running restarts execution from address zero.
// RULE_05: Low supply longer than qualify time resets and sets the dip flag.
// RULE_06: Low supply not longer than qualify time is ignored.
// RULE_07: Threshold codes 55, 33, 99, aa select 2.1, 2.55, 3.15, 3.8 V.
// RULE_08: Bad code: reset after 2-3 slow clocks, error flag set, code 55.
// RULE_09: Real dip with valid code resets after 2-3 slow clocks, code kept.
// RULE_10: Supply dip reset is disabled while in power-down.
// RULE_11: Watchdog timeout in run acts as pin reset and sets timeout flag.
// RULE_12: Watchdog timeout in halt clears only PC and SP, sets timeout flag.
// RULE_13: Wake-up waits 1024 or 2 system clocks; crystal always 1024.
// RULE_14: Timeout/power-down flags follow the reset-kind table.
// RULE_15: After reset interrupts off, watchdog cleared, timers off, SP to top.
// RULE_16: Except watchdog wake: timer ctl 08, interrupt and system ctl 00.
// RULE_17: Power-down flag cleared at power-up or watchdog clear, set on halt.
// RULE_18: Pin and detector synchronised; reset released synchronously.
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
`define RSC_ADDR_THRESH    12'h000
`define RSC_ADDR_FLAGS     12'h004
`define RSC_ADDR_IRQSTAT   12'h008
`define RSC_ADDR_IRQMASK   12'h00c
`define RSC_ADDR_CONFIG    12'h010
`define RSC_THRESH_RESET   8'h55
`define RSC_THRESH_2V55    8'h33
`define RSC_THRESH_3V15    8'h99
`define RSC_THRESH_3V80    8'haa
`define RSC_TMRC_RESET     8'h08
`define RSC_INTC_RESET     8'h00
`define RSC_SYSC_RESET     8'h00
`define RSC_STARTUP_MS     100
`define RSC_CLK_KHZ        25000
`define RSC_STARTUP_CYC    (`RSC_STARTUP_MS * `RSC_CLK_KHZ)
`define RSC_SETTLE_LONG    11'h400
`define RSC_SETTLE_SHORT   11'h002
`define RSC_SLOW_TICKS     2'h2
`define RSC_QUALIFY_CYC    8'h19
`define RSC_FLAG_DIP       0
`define RSC_FLAG_CODEERR   1
`define RSC_FLAG_TIMEOUT   2
`define RSC_FLAG_PDOWN     3
`endif

// file: rsc_reset_source_controller.v
// Purpose: Reset source arbitration, start-up hold and reset flags.
// Assumes: Pin and supply detector are asynchronous; slow RC tick is a
//          one-cycle enable on clk_sys.
// Notes:   Dip and code-error flags and interrupt status are cleared by writing ones.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "rsc_consts.vh"

module rsc_reset_source_controller #(
   parameter STARTUP_CYC = `RSC_STARTUP_CYC
) (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        resetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Reset sources
   input  wire        extResetPinN,
   input  wire        supplyLow,
   input  wire        slowRcTick,
   input  wire        watchdogTimeout,
   input  wire        haltExec,
   input  wire        watchdogClear,
   input  wire        crystalClock,
   // Core reset outputs
   output reg         coreResetHold,
   output reg         warmResetPulse,
   output reg  [7:0]  portDataInit,
   output reg  [7:0]  portDirInit,
   output reg  [7:0]  timerZeroControl,
   output reg  [7:0]  timerOneControl,
   output reg  [7:0]  interruptControlZero,
   output reg  [7:0]  systemControlZero,
   output reg  [1:0]  supplyThresholdSel,
   output reg         powerDownMode,
   output reg         irq
);

   // ************************************************************
   // State and declarations
   // ************************************************************
   localparam ST_POR   = 3'h0;
   localparam ST_HOLD  = 3'h1;
   localparam ST_RUN   = 3'h2;
   localparam ST_HALT  = 3'h3;
   localparam ST_WAKE  = 3'h4;
   localparam ST_PINLO = 3'h5;

   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [31:0] count_reg;
   reg  [31:0] count_next;
   reg         pinMeta_reg;
   reg         pinSync_reg;
   reg         lowMeta_reg;
   reg         lowSync_reg;
   reg  [7:0]  lowCount_reg;
   reg         dipQualified_reg;
   reg  [1:0]  dipSlow_reg;
   reg  [1:0]  errSlow_reg;
   reg  [7:0]  threshold_reg;
   reg         dipFlag_reg;
   reg         codeErrFlag_reg;
   reg         timeoutFlag_reg;
   reg         pdownFlag_reg;
   reg  [3:0]  irqStat_reg;
   reg  [3:0]  irqMask_reg;
   reg         fastSettle_reg;
   wire        wrEn;
   wire        codeValid;
   wire        dipFire;
   wire        errFire;
   wire        pinLow;
   wire        fullReset;
   wire        wdRun;
   wire        wdWake;
   wire        pinWake;
   wire        flagWrite;
   wire        statWrite;
   wire [3:0]  eventBits;

   // Valid threshold codes map to a two-bit level select.
   function is_valid_code;
      input [7:0] code;
      begin
         is_valid_code = (code == `RSC_THRESH_RESET) ||
                         (code == `RSC_THRESH_2V55) ||
                         (code == `RSC_THRESH_3V15) ||
                         (code == `RSC_THRESH_3V80);
      end
   endfunction

   function [1:0] level_of;
      input [7:0] code;
      begin
         case (code)
            `RSC_THRESH_2V55: level_of = 2'h1;
            `RSC_THRESH_3V15: level_of = 2'h2;
            `RSC_THRESH_3V80: level_of = 2'h3;
            default:          level_of = 2'h0;
         endcase
      end
   endfunction

   assign wrEn      = psel && penable && pwrite;
   assign codeValid = is_valid_code(threshold_reg);
   assign pinLow    = !pinSync_reg;
   assign dipFire   = slowRcTick && (dipSlow_reg == `RSC_SLOW_TICKS);
   assign errFire   = slowRcTick && (errSlow_reg == `RSC_SLOW_TICKS);
   assign wdRun     = (state_reg == ST_RUN) && watchdogTimeout;
   assign wdWake    = (state_reg == ST_HALT) && watchdogTimeout;
   assign pinWake   = (state_reg == ST_HALT) && pinLow;
   // Pin, dip and code error share one full-reset path.
   assign fullReset = (pinLow && state_reg != ST_HALT) || dipFire ||
                      errFire; // RULE_01
   assign flagWrite = wrEn && (paddr == `RSC_ADDR_FLAGS);
   assign statWrite = wrEn && (paddr == `RSC_ADDR_IRQSTAT);
   assign eventBits = {wdRun | wdWake, pinLow & (state_reg != ST_PINLO),
                       errFire, dipFire};

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   always @(posedge clk_sys) begin
      if (!resetn) begin
         pinMeta_reg <= 1'b1;
         pinSync_reg <= 1'b1;
         lowMeta_reg <= 1'b0;
         lowSync_reg <= 1'b0;
      end else begin
         pinMeta_reg <= extResetPinN; // RULE_18
         pinSync_reg <= pinMeta_reg;
         lowMeta_reg <= supplyLow; // RULE_18
         lowSync_reg <= lowMeta_reg;
      end
   end

   // ************************************************************
   // Supply dip qualification and slow-clock delays
   // ************************************************************
   // The detector is ignored in halt so a dip there cannot wake the core.
   always @(posedge clk_sys) begin
      if (!resetn) begin
         lowCount_reg     <= 8'h00;
         dipQualified_reg <= 1'b0;
         dipSlow_reg      <= 2'h0;
         errSlow_reg      <= 2'h0;
      end else begin
         if (!lowSync_reg || powerDownMode) begin // RULE_10
            lowCount_reg     <= 8'h00;
            dipQualified_reg <= 1'b0;
         end else if (lowCount_reg == `RSC_QUALIFY_CYC) begin
            dipQualified_reg <= 1'b1; // RULE_05
         end else begin
            lowCount_reg <= lowCount_reg + 8'h01; // RULE_06
         end
         if (!dipQualified_reg || !codeValid || dipFire)
            dipSlow_reg <= 2'h0;
         else if (slowRcTick)
            dipSlow_reg <= dipSlow_reg + 2'h1; // RULE_09
         if (codeValid || errFire)
            errSlow_reg <= 2'h0;
         else if (slowRcTick)
            errSlow_reg <= errSlow_reg + 2'h1; // RULE_08
      end
   end

   // ************************************************************
   // Reset sequencer
   // ************************************************************
   always @* begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         ST_POR: begin
            state_next = ST_HOLD;
            count_next = STARTUP_CYC;
         end
         ST_HOLD: begin
            if (pinLow) begin
               state_next = ST_PINLO;
            end else if (count_reg == 32'h0) begin
               state_next = ST_RUN; // RULE_03
            end else begin
               count_next = count_reg - 32'h1;
            end
         end
         ST_RUN: begin
            if (pinLow) begin
               state_next = ST_PINLO; // RULE_04
            end else if (fullReset || wdRun) begin
               state_next = ST_HOLD; // RULE_11
               count_next = STARTUP_CYC;
            end else if (haltExec) begin
               state_next = ST_HALT;
            end
         end
         ST_PINLO: begin
            if (!pinLow) begin
               state_next = ST_HOLD;
               count_next = STARTUP_CYC;
            end
         end
         ST_HALT: begin
            if (pinWake) begin
               state_next = ST_PINLO;
            end else if (wdWake) begin
               state_next = ST_WAKE;
               count_next = (fastSettle_reg && !crystalClock) ?
                            {21'h0, `RSC_SETTLE_SHORT} :
                            {21'h0, `RSC_SETTLE_LONG}; // RULE_13
            end
         end
         ST_WAKE: begin
            // A pin pulled low during the settle time still wins.
            if (pinLow)
               state_next = ST_PINLO; // RULE_04
            else if (count_reg == 32'h0)
               state_next = ST_RUN;
            else
               count_next = count_reg - 32'h1;
         end
         default: begin
            state_next = ST_POR;
         end
      endcase
   end

   // ************************************************************
   // Sequencer registers, flags and core reset values
   // ************************************************************
   always @(posedge clk_sys) begin
      if (!resetn) begin
         state_reg            <= ST_POR;
         count_reg            <= 32'h0;
         coreResetHold        <= 1'b1; // RULE_01
         warmResetPulse       <= 1'b0;
         portDataInit         <= 8'hff; // RULE_02
         portDirInit          <= 8'hff; // RULE_02
         timerZeroControl     <= `RSC_TMRC_RESET;
         timerOneControl      <= `RSC_TMRC_RESET;
         interruptControlZero <= `RSC_INTC_RESET;
         systemControlZero    <= `RSC_SYSC_RESET;
         powerDownMode        <= 1'b0;
         timeoutFlag_reg      <= 1'b0; // RULE_14
         pdownFlag_reg        <= 1'b0; // RULE_17
      end else begin
         state_reg      <= state_next;
         count_reg      <= count_next;
         coreResetHold  <= (state_next == ST_HOLD) ||
                           (state_next == ST_PINLO) ||
                           (state_next == ST_POR); // RULE_18
         warmResetPulse <= (state_next == ST_RUN) &&
                           (state_reg == ST_WAKE); // RULE_12
         powerDownMode  <= (state_next == ST_HALT) ||
                           (state_next == ST_WAKE);
         if (state_next == ST_HOLD || state_next == ST_PINLO) begin
            // Every reset but the watchdog wake reloads these.
            timerZeroControl     <= `RSC_TMRC_RESET; // RULE_16
            timerOneControl      <= `RSC_TMRC_RESET; // RULE_16
            interruptControlZero <= `RSC_INTC_RESET; // RULE_15
            systemControlZero    <= `RSC_SYSC_RESET; // RULE_16
            portDataInit         <= 8'hff;
            portDirInit          <= 8'hff;
         end
         // Flag table: pin wake 0,1; watchdog run 1,u; watchdog wake 1,1.
         if (wdRun || wdWake)
            timeoutFlag_reg <= 1'b1; // RULE_14
         else if (pinWake || (haltExec && state_reg == ST_RUN))
            timeoutFlag_reg <= 1'b0;
         if (haltExec && state_reg == ST_RUN)
            pdownFlag_reg <= 1'b1; // RULE_17
         else if (watchdogClear && state_reg == ST_RUN)
            pdownFlag_reg <= 1'b0; // RULE_17
      end
   end

   // ************************************************************
   // Register file and interrupt
   // ************************************************************
   always @(posedge clk_sys) begin
      if (!resetn) begin
         threshold_reg      <= `RSC_THRESH_RESET;
         supplyThresholdSel <= 2'h0;
         dipFlag_reg        <= 1'b0;
         codeErrFlag_reg    <= 1'b0;
         irqStat_reg        <= 4'h0;
         irqMask_reg        <= 4'h0;
         fastSettle_reg     <= 1'b0;
         irq                <= 1'b0;
      end else begin
         supplyThresholdSel <= level_of(threshold_reg); // RULE_07
         if (errFire)
            threshold_reg <= `RSC_THRESH_RESET; // RULE_08
         else if (wrEn && paddr == `RSC_ADDR_THRESH)
            threshold_reg <= pwdata[7:0];
         else if (wdRun || (pinLow && (state_reg == ST_RUN ||
                  state_reg == ST_HALT)))
            threshold_reg <= `RSC_THRESH_RESET; // RULE_11
         // Hardware set wins over a software clear in the same cycle.
         if (dipFire)
            dipFlag_reg <= 1'b1; // RULE_05
         else if (flagWrite && pwdata[`RSC_FLAG_DIP])
            dipFlag_reg <= 1'b0;
         if (errFire)
            codeErrFlag_reg <= 1'b1; // RULE_08
         else if (flagWrite && pwdata[`RSC_FLAG_CODEERR])
            codeErrFlag_reg <= 1'b0;
         irqStat_reg <= eventBits |
                        (irqStat_reg & ~({4{statWrite}} & pwdata[3:0]));
         if (wrEn && paddr == `RSC_ADDR_IRQMASK)
            irqMask_reg <= pwdata[3:0];
         if (wrEn && paddr == `RSC_ADDR_CONFIG)
            fastSettle_reg <= pwdata[0];
         irq <= |(irqStat_reg & irqMask_reg);
      end
   end

   // No wait state: the answer comes in the first access cycle.
   always @(posedge clk_sys) begin
      if (!resetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               `RSC_ADDR_THRESH:  prdata <= {24'h0, threshold_reg};
               `RSC_ADDR_FLAGS:   prdata <= {28'h0, pdownFlag_reg,
                                             timeoutFlag_reg,
                                             codeErrFlag_reg, dipFlag_reg};
               `RSC_ADDR_IRQSTAT: prdata <= {28'h0, irqStat_reg};
               `RSC_ADDR_IRQMASK: prdata <= {28'h0, irqMask_reg};
               `RSC_ADDR_CONFIG:  prdata <= {31'h0, fastSettle_reg};
               default: begin
                  prdata  <= 32'h0;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule // rsc_reset_source_controller

// file: rsc_reset_source_controller_props.sv
// Purpose: Concurrent checks on the reset source controller ports.
// Assumes: One clock domain, reset active low and synchronous.
// Notes:   Bound into the design from the bench top file.
`timescale 1ns/1ps
module rsc_reset_source_controller_props #(
   parameter STARTUP_CYC = 20
) (
   // Clock and reset
   input wire       clk_sys,
   input wire       resetn,
   // Reset sources
   input wire       extResetPinN,
   input wire       watchdogTimeout,
   input wire       haltExec,
   // Core reset outputs
   input wire       coreResetHold,
   input wire       warmResetPulse,
   input wire [7:0] portDataInit,
   input wire [7:0] portDirInit,
   input wire [7:0] timerZeroControl,
   input wire [7:0] timerOneControl,
   input wire [7:0] interruptControlZero,
   input wire [7:0] systemControlZero,
   input wire       powerDownMode
);
   reg [31:0] holdCnt_reg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Counts held cycles so the release can be tied to the full delay.
   always @(posedge clk_sys)
      if (!resetn || !coreResetHold)
         holdCnt_reg <= 32'h0;
      else
         holdCnt_reg <= holdCnt_reg + 32'h1;
   startup_len_a: assert property (
      $fell(coreResetHold) |-> holdCnt_reg >= STARTUP_CYC)
      else $error("core reset released too early");
   port_init_a: assert property (
      coreResetHold[*2] |-> portDataInit == 8'hff && portDirInit == 8'hff)
      else $error("ports not preset during reset");
   ctl_init_a: assert property (
      coreResetHold[*2] |-> timerZeroControl == 8'h08 &&
      timerOneControl == 8'h08 && interruptControlZero == 8'h00 &&
      systemControlZero == 8'h00)
      else $error("control registers not preset");
   pin_take_a: assert property (
      !extResetPinN[*5] |-> coreResetHold)
      else $error("pin low did not hold core");
   pin_sync_a: assert property (
      $fell(extResetPinN) && !coreResetHold |=> !coreResetHold)
      else $error("pin reached core without synchroniser");
   warm_keep_a: assert property (
      warmResetPulse |-> !coreResetHold && $stable(portDataInit) &&
      $stable(timerZeroControl) && $stable(interruptControlZero) &&
      $stable(systemControlZero))
      else $error("warm wake disturbed state");
   pd_nodip_a: assert property (
      (powerDownMode && extResetPinN)[*4] |=> !coreResetHold)
      else $error("full reset while powered down");
   halt_enter_a: assert property (
      haltExec && !coreResetHold && !powerDownMode |-> ##[1:2] powerDownMode)
      else $error("halt did not enter power-down");
   wd_run_a: assert property (
      watchdogTimeout && !coreResetHold && !powerDownMode
      |-> ##[1:4] coreResetHold)
      else $error("watchdog in run gave no reset");
   wd_halt_a: assert property (
      watchdogTimeout && powerDownMode |=> !coreResetHold[*8])
      else $error("watchdog in halt gave full reset");
   cover property ($fell(coreResetHold));
   cover property (warmResetPulse);
   cover property ($rose(powerDownMode));
endmodule // rsc_reset_source_controller_props

// file: rsc_pin_supply_model.sv
// Purpose: Far side: reset pin driver, supply detector, slow RC tick.
// Assumes: Pin has a pull-up, so released means high.
// Notes:   The slow tick runs free, one pulse every four cycles.
`timescale 1ns/1ps
module rsc_pin_supply_model (
   // Clock
   input  wire clk_sys,
   // Bench commands
   input  wire pinReq,
   input  wire dipReq,
   // Toward the block
   output wire extResetPinN,
   output wire supplyLow,
   output reg  slowRcTick = 1'b0
);
   reg [1:0] tickDiv_reg = 2'h0;
   assign extResetPinN = ~pinReq;
   assign supplyLow = dipReq;
   always @(posedge clk_sys) begin
      tickDiv_reg <= tickDiv_reg + 2'h1;
      slowRcTick <= (tickDiv_reg == 2'h3);
   end
endmodule // rsc_pin_supply_model

// file: rsc_reset_source_controller_bench.sv
// Purpose: Self-checking bench for the reset source controller.
// Assumes: Start-up hold shortened to 20 cycles by parameter.
// Notes:   Threshold codes and halt settle cases run from tables, the rest by hand.
`timescale 1ns/1ps
module rsc_reset_source_controller_bench;
   localparam STARTUP_CYC = 20;
   reg         clk_sys = 1'b0;
   reg         resetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   reg         pinReq = 1'b0;
   reg         dipReq = 1'b0;
   reg  [2:0]  ev = 3'h0;
   reg         crystalClock = 1'b0;
   wire [31:0] prdata;
   wire        pready, pslverr, extResetPinN, supplyLow, slowRcTick;
   wire        coreResetHold, warmResetPulse, powerDownMode, irq;
   wire [7:0]  portDataInit, portDirInit, timerZeroControl;
   wire [7:0]  timerOneControl, interruptControlZero, systemControlZero;
   wire [1:0]  supplyThresholdSel;
   reg  [31:0] rdat;
   reg         errs;
   reg  [9:0]  rows [0:3];
   reg  [12:0] halts [0:2];
   integer     failCount = 0, samplesChecked = 0, cycles = 0, i, n, k;
   rsc_pin_supply_model far (.clk_sys(clk_sys), .pinReq(pinReq),
      .dipReq(dipReq), .extResetPinN(extResetPinN),
      .supplyLow(supplyLow), .slowRcTick(slowRcTick));
   rsc_reset_source_controller #(.STARTUP_CYC(STARTUP_CYC)) DUT (
      .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .extResetPinN(extResetPinN),
      .supplyLow(supplyLow), .slowRcTick(slowRcTick),
      .watchdogTimeout(ev[0]), .haltExec(ev[1]), .watchdogClear(ev[2]),
      .crystalClock(crystalClock), .coreResetHold(coreResetHold),
      .warmResetPulse(warmResetPulse), .portDataInit(portDataInit),
      .portDirInit(portDirInit), .timerZeroControl(timerZeroControl),
      .timerOneControl(timerOneControl),
      .interruptControlZero(interruptControlZero),
      .systemControlZero(systemControlZero),
      .supplyThresholdSel(supplyThresholdSel),
      .powerDownMode(powerDownMode), .irq(irq));
   // ****
   // Helpers
   // ****
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failCount = failCount + 1;
         testDone;
      end
   end
   task testDone;
      begin
         $display("checks %0d mismatches %0d", samplesChecked, failCount);
         if (failCount == 0 && samplesChecked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task chk(input [8*16:1] nm, input [31:0] e, input [31:0] g);
      begin
         samplesChecked = samplesChecked + 1;
         if (g !== e) begin
            failCount = failCount + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // Pready and read data are taken at the rising edge that ends the
   // access; only then is the request dropped.
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_sys);
         penable <= 1'b1;
         @(posedge clk_sys);
         while (pready !== 1'b1) @(posedge clk_sys);
         rdat = prdata;
         errs = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task waitFor(input integer s, input integer lim);
      begin
         n = 0;
         @(negedge clk_sys);
         while (n < lim && !(s == 0 ? coreResetHold === 1'b1 : s == 1 ?
                coreResetHold === 1'b0 : warmResetPulse === 1'b1)) begin
            n = n + 1;
            @(negedge clk_sys);
         end
         @(posedge clk_sys);
      end
   endtask
   task pulse(input [2:0] m);
      begin
         ev <= m;
         @(posedge clk_sys);
         ev <= 3'h0;
         @(posedge clk_sys);
      end
   endtask
   task fullReset;
      begin
         waitFor(0, 80);
         chk("reset seen", 1, n < 80);
         pinReq <= 1'b0;
         dipReq <= 1'b0;
         waitFor(1, 200);
         chk("ports", 32'hffff, {portDataInit, portDirInit});
         chk("ctl", 32'h08080000, {timerZeroControl, timerOneControl,
             interruptControlZero, systemControlZero});
      end
   endtask
   task irqChk(input e);
      begin
         repeat (2) @(negedge clk_sys);
         chk("irq", e, irq);
         @(posedge clk_sys);
      end
   endtask
   // ****
   // Tests
   // ****
   initial begin
      rows[0] = {2'h1, 8'h33};
      rows[1] = {2'h2, 8'h99};
      rows[2] = {2'h3, 8'haa};
      rows[3] = {2'h0, 8'h55};
      halts[0] = {2'h2, 11'h002};
      halts[1] = {2'h3, 11'h400};
      halts[2] = {2'h0, 11'h400};
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      fullReset;
      apb(0, 12'h000, 0);
      chk("thresh por", 32'h55, rdat);
      apb(0, 12'h004, 0);
      chk("flags por", 0, rdat[3:0]);
      for (i = 0; i < 4; i = i + 1) begin
         apb(1, 12'h000, {24'h0, rows[i][7:0]});
         apb(0, 12'h000, 0);
         chk("thresh rd", rows[i][7:0], rdat);
         chk("thresh sel", rows[i][9:8], supplyThresholdSel);
      end
      $display("test codes done");
      apb(1, 12'h000, 32'h12);
      fullReset;
      apb(0, 12'h000, 0);
      chk("code restored", 32'h55, rdat);
      apb(0, 12'h004, 0);
      chk("code err flag", 1, rdat[1]);
      apb(1, 12'h00c, 32'h2);
      irqChk(1'b1);
      apb(1, 12'h00c, 32'h0);
      irqChk(1'b0);
      apb(1, 12'h00c, 32'h2);
      apb(1, 12'h008, 32'h2);
      irqChk(1'b0);
      apb(1, 12'h004, 32'h2);
      apb(0, 12'h004, 0);
      chk("flag cleared", 0, rdat[1]);
      apb(0, 12'h100, 0);
      chk("unmapped data", 0, rdat);
      chk("unmapped err", 1, errs);
      $display("test bad code done");
      dipReq <= 1'b1;
      repeat (10) @(posedge clk_sys);
      dipReq <= 1'b0;
      waitFor(0, 60);
      chk("short dip", 60, n);
      apb(1, 12'h000, 32'h99);
      dipReq <= 1'b1;
      fullReset;
      apb(0, 12'h000, 0);
      chk("code kept", 32'h99, rdat);
      apb(0, 12'h004, 0);
      chk("dip flag", 1, rdat[0]);
      $display("test dip done");
      for (k = 0; k < 3; k = k + 1) begin
         apb(1, 12'h010, {31'h0, halts[k][12]});
         crystalClock <= halts[k][11];
         pulse(3'h2);
         apb(0, 12'h004, 0);
         chk("halt flags", 2'h2, rdat[3:2]);
         dipReq <= 1'b1;
         waitFor(0, 60);
         chk("dip in halt", 60, n);
         dipReq <= 1'b0;
         pulse(3'h1);
         waitFor(2, 1100);
         chk("settle", 1, n + 2 >= halts[k][10:0] &&
             n <= halts[k][10:0] + 6);
         apb(0, 12'h004, 0);
         chk("wake flags", 2'h3, rdat[3:2]);
         pulse(3'h4);
         apb(0, 12'h004, 0);
         chk("pdown clear", 0, rdat[3]);
      end
      $display("test halt done");
      pulse(3'h2);
      pinReq <= 1'b1;
      fullReset;
      apb(0, 12'h004, 0);
      chk("pin wake", 2'h2, rdat[3:2]);
      apb(0, 12'h000, 0);
      chk("pin wake code", 32'h55, rdat);
      apb(1, 12'h000, 32'haa);
      pinReq <= 1'b1;
      fullReset;
      apb(0, 12'h004, 0);
      chk("pin run", 2'h2, rdat[3:2]);
      apb(0, 12'h000, 0);
      chk("pin code", 32'h55, rdat);
      apb(1, 12'h000, 32'h33);
      pulse(3'h1);
      fullReset;
      apb(0, 12'h004, 0);
      chk("wd run", 2'h3, rdat[3:2]);
      apb(0, 12'h000, 0);
      chk("wd run code", 32'h55, rdat);
      $display("test pin and watchdog done");
      testDone;
   end
endmodule // rsc_reset_source_controller_bench
bind rsc_reset_source_controller rsc_reset_source_controller_props
   #(.STARTUP_CYC(STARTUP_CYC)) props (.clk_sys(clk_sys),
   .resetn(resetn), .extResetPinN(extResetPinN),
   .watchdogTimeout(watchdogTimeout), .haltExec(haltExec),
   .coreResetHold(coreResetHold), .warmResetPulse(warmResetPulse),
   .portDataInit(portDataInit), .portDirInit(portDirInit),
   .timerZeroControl(timerZeroControl), .timerOneControl(timerOneControl),
   .interruptControlZero(interruptControlZero),
   .systemControlZero(systemControlZero), .powerDownMode(powerDownMode));
